/* File: src/dmi_pkg.sv */
// Constants, types and helper functions of the DDR2 module command and data interface.
`default_nettype none
package dmi_pkg;
   // Data path widths and burst shape.
   localparam int DQ_W   = 64;
   localparam int CB_W   = 8;
   localparam int WORD_W = DQ_W + CB_W;
   localparam int LANES  = 9;
   localparam int BURST  = 4;
   localparam int CORE_W = WORD_W * BURST;
   localparam int KEEP_W = CORE_W / 8;
   // Address fields.
   localparam int ADDR_W  = 16;
   localparam int BA_W    = 3;
   localparam int COL_W   = 2;
   localparam int COL_LSB = 2;
   localparam int MEM_AW  = BA_W + COL_W;
   // Read latency; the output burst starts RD_FIRST = RD_LAT + 2 cycles after a taken read.
   localparam logic [1:0] RD_LAT = 2'h2;
   // Command codes on {row strobe, column strobe, write enable}.
   localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
   localparam logic [2:0] CMD_WRITE     = 3'h4;
   localparam logic [2:0] CMD_READ      = 3'h5;
   // Extended mode register select and its option bits.
   localparam logic [2:0] BA_EXT_MODE   = 3'h1;
   localparam int         ODT_ALLOW_BIT = 2;
   localparam int         DIFF_DQS_BIT  = 10;
   // Reset values of the mode options.
   localparam logic       ODT_ALLOW_RST = 1'h0;
   localparam logic       DIFF_DQS_RST  = 1'h0;
   // Upper bits of the presence-detect bus address.
   localparam logic [4:0] PRESENCE_BASE = 5'h14;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'h0,
      ST_RD_WAIT   = 3'h1,
      ST_RD_BURST  = 3'h3,
      ST_WR_CAPT   = 3'h4,
      ST_WR_COMMIT = 3'h5
   } dmi_state_type;

   typedef enum logic [1:0] {
      DEN_256M = 2'h0,
      DEN_512M = 2'h1,
      DEN_1G   = 2'h2
   } dmi_density_type;

   // Four banks drop the top bank bit; eight banks use all three.
   function automatic logic [BA_W-1:0] bank_index(dmi_density_type d, logic [BA_W-1:0] ba);
      bank_index = (d == DEN_1G) ? ba : {1'b0, ba[1:0]};
   endfunction

   // True when a decoded command matches a given code.
   function automatic logic is_cmd(logic ras_n, logic cas_n, logic we_n, logic [2:0] code);
      is_cmd = ({ras_n, cas_n, we_n} == code);
   endfunction
endpackage
`default_nettype wire

/* File: src/dmi_core_mem.sv */
// Core array written and read four words at a time, registered read data.
`timescale 1ns/100ps
`default_nettype none
module dmi_core_mem (
   // Clock and freeze.
   input  wire logic                        ref_clk,
   input  wire logic                        clk_en,
   // Write port with byte keep.
   input  wire logic                        wr_en,
   input  wire logic [dmi_pkg::MEM_AW-1:0]  wr_addr,
   input  wire logic [dmi_pkg::CORE_W-1:0]  wr_data,
   input  wire logic [dmi_pkg::KEEP_W-1:0]  wr_keep,
   // Read port.
   input  wire logic                        rd_en,
   input  wire logic [dmi_pkg::MEM_AW-1:0]  rd_addr,
   output logic      [dmi_pkg::CORE_W-1:0]  rd_data
);
   import dmi_pkg::*;

   logic [CORE_W-1:0] mem [2**MEM_AW];

   // Masked bytes keep their old contents.
   always_ff @(posedge ref_clk) begin
      if (clk_en && wr_en) begin
         for (int i = 0; i < KEEP_W; i++) begin
            if (wr_keep[i]) begin
               mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
            end
         end
      end
   end

   // Read data holds until the next read so a late burst still sees it.
   always_ff @(posedge ref_clk) begin
      if (clk_en && rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

/* File: src/dmi_pin_sync.sv */
// Three-stage synchroniser that passes a change once two stages agree.
`timescale 1ns/100ps
`default_nettype none
module dmi_pin_sync #(
   parameter int W = 2
) (
   // Clock, reset and freeze.
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   // Pin and filtered level.
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   // Only the second stage reads the first, to keep metastability contained.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         level <= '0;
      end else if (clk_en) begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            level <= s3_ff;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/dmi_module_if.sv */
// Command decoder, termination and double-rate data path of the memory module.
// How it works
// R1: Sampled termination enable switches data-pin termination on when high, off when low; here on only once a mode load sets the allow bit, which reset clears.
// R2: Termination acts only on data, strobes, mask and check-bit pins.
// R3: After a mode load disables termination, the enable input is ignored.
// R4: Row strobe, column strobe, write enable and chip select encode each command.
// R5: Chip select low enables the command decoder; high makes it ignore commands.
// R6: Module reset forces all registered outputs low without a clock; the active-low drive enables go high instead.
// R7: Controller should hold reset during power-up, keeping pins quiet.
// R8: Complementary strobe is used only after differential mode is loaded.
// R9: On reads the device drives the strobe, edge-aligned with data.
// R10: On writes the controller drives the strobe centered in the data.
// R11: Each access is one four-word core transfer and four pin words.
// R12: Commands are sampled when true clock rises and complement falls.
// R13: Write data is captured on both strobe edges.
// R14: Read data is timed to both strobe edges and both clock edges.
// R15: One 64-bit bidirectional data bus carries writes in and reads out.
// R16: Four banks at the two smaller densities, eight at the largest.
// R17: Two serial address pins set the presence-detect bus address.
// R18: Data with the mask sampled high is left unwritten.
// R19: Sampled clock enable enables the internal logic when high.
// R20: Controller keeps termination low and data undriven until initialised.
`timescale 1ns/100ps
`default_nettype none
module dmi_module_if #(
   parameter dmi_pkg::dmi_density_type DENSITY = dmi_pkg::DEN_1G
) (
   // Clock, reset and freeze.
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   input  wire logic                        clk_en,
   // Differential memory clock and its enable.
   input  wire logic                        ck_t,
   input  wire logic                        ck_c,
   input  wire logic                        clock_enable_in,
   // Command, address and termination.
   input  wire logic                        chip_select_n,
   input  wire logic                        ras_n,
   input  wire logic                        cas_n,
   input  wire logic                        we_n,
   input  wire logic [dmi_pkg::ADDR_W-1:0]  addr,
   input  wire logic [dmi_pkg::BA_W-1:0]    bank_addr,
   input  wire logic                        termination_enable,
   output logic                             data_term_on,
   // Presence-detect address straps.
   input  wire logic [1:0]                  presence_addr_select,
   output logic      [6:0]                  presence_dev_addr,
   // Data, check bits and mask.
   input  wire logic [dmi_pkg::DQ_W-1:0]    dq_in,
   output logic      [dmi_pkg::DQ_W-1:0]    dq_out,
   output logic      [dmi_pkg::DQ_W-1:0]    dq_drive_n,
   input  wire logic [dmi_pkg::CB_W-1:0]    check_bits_in,
   output logic      [dmi_pkg::CB_W-1:0]    check_bits_out,
   output logic      [dmi_pkg::CB_W-1:0]    check_bits_drive_n,
   input  wire logic [dmi_pkg::LANES-1:0]   write_byte_mask,
   // Data strobes, true and complementary.
   input  wire logic [dmi_pkg::LANES-1:0]   dqs_in,
   output logic      [dmi_pkg::LANES-1:0]   dqs_out,
   output logic      [dmi_pkg::LANES-1:0]   dqs_drive_n,
   input  wire logic [dmi_pkg::LANES-1:0]   dqs_c_in,
   output logic      [dmi_pkg::LANES-1:0]   dqs_c_out,
   output logic      [dmi_pkg::LANES-1:0]   dqs_c_drive_n
);
   import dmi_pkg::*;

   localparam int RD_FIRST = int'(RD_LAT) + 2;

   dmi_state_type     state_ff;
   logic              ck_t_ff;
   logic              ck_c_ff;
   logic              cke_ff;
   logic              odt_allow_ff;
   logic              diff_dqs_ff;
   logic              term_ff;
   logic [1:0]        lat_ff;
   logic [1:0]        beat_ff;
   logic [MEM_AW-1:0] slot_ff;
   logic              dqs_prev_ff;
   logic [CORE_W-1:0] wbuf_ff;
   logic [KEEP_W-1:0] wkeep_ff;
   logic [WORD_W-1:0] word_out_ff;
   logic              drive_ff;
   logic              strobe_ff;
   logic [CORE_W-1:0] core_rd;
   logic [1:0]        presence_sel;
   logic              ck_pos;
   logic              cmd_take;
   logic              rd_take;
   logic              wr_take;
   logic              mode_take;
   logic              wr_edge;
   logic [MEM_AW-1:0] cmd_slot;

   // A positive clock edge is the true clock rising while the complement falls.
   assign ck_pos = ck_t && !ck_t_ff && !ck_c && ck_c_ff; // see R12

   // Commands are taken only in idle, with clock enable and chip select active.
   assign cmd_take  = ck_pos && cke_ff && !chip_select_n && (state_ff == ST_IDLE); // see R5
   assign rd_take   = cmd_take && is_cmd(ras_n, cas_n, we_n, CMD_READ); // see R4
   assign wr_take   = cmd_take && is_cmd(ras_n, cas_n, we_n, CMD_WRITE); // see R4
   assign mode_take = cmd_take && is_cmd(ras_n, cas_n, we_n, CMD_LOAD_MODE) && (bank_addr == BA_EXT_MODE);

   // The top bank bit only counts at the largest density.
   assign cmd_slot = {bank_index(DENSITY, bank_addr), addr[COL_LSB +: COL_W]}; // see R16

   // Each strobe change marks one write word; in differential mode the pair must disagree.
   assign wr_edge = (dqs_in[0] != dqs_prev_ff) && (!diff_dqs_ff || (dqs_c_in[0] != dqs_in[0])); // see R13, R8, R10

   // Clock history and clock enable sample; the enable is caught only on clock edges.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ck_t_ff     <= 1'b0;
         ck_c_ff     <= 1'b0;
         cke_ff      <= 1'b0;
         dqs_prev_ff <= 1'b0;
      end else if (clk_en) begin
         ck_t_ff     <= ck_t;
         ck_c_ff     <= ck_c;
         dqs_prev_ff <= dqs_in[0];
         if (ck_pos) begin
            cke_ff <= clock_enable_in; // see R19
         end
      end
   end

   // Extended mode options loaded by the mode command.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         odt_allow_ff <= ODT_ALLOW_RST;
         diff_dqs_ff  <= DIFF_DQS_RST;
      end else if (clk_en && mode_take) begin
         odt_allow_ff <= addr[ODT_ALLOW_BIT];
         diff_dqs_ff  <= addr[DIFF_DQS_BIT]; // see R8
      end
   end

   // Termination follows the sampled enable, and is held off when the mode forbids it.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         term_ff <= 1'b0;
      end else if (clk_en && ck_pos) begin
         term_ff <= odt_allow_ff && termination_enable; // see R1, R3
      end
   end

   // One output covers the data group only; address and command pins never terminate.
   assign data_term_on = term_ff; // see R2

   // Sequencer for read and write bursts.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         lat_ff   <= 2'h0;
         beat_ff  <= 2'h0;
         slot_ff  <= '0;
      end else if (clk_en) begin
         case (state_ff)
            ST_IDLE: begin
               beat_ff <= 2'h0;
               lat_ff  <= RD_LAT - 2'h1;
               if (rd_take) begin
                  state_ff <= ST_RD_WAIT;
               end else if (wr_take) begin
                  state_ff <= ST_WR_CAPT;
                  slot_ff  <= cmd_slot;
               end
            end
            ST_RD_WAIT: begin
               if (lat_ff == 2'h0) begin
                  state_ff <= ST_RD_BURST;
               end else begin
                  lat_ff <= lat_ff - 2'h1;
               end
            end
            ST_RD_BURST: begin
               beat_ff <= beat_ff + 2'h1;
               if (beat_ff == 2'(BURST - 1)) begin
                  state_ff <= ST_IDLE; // see R11
               end
            end
            ST_WR_CAPT: begin
               if (wr_edge) begin
                  beat_ff <= beat_ff + 2'h1;
                  if (beat_ff == 2'(BURST - 1)) begin
                     state_ff <= ST_WR_COMMIT;
                  end
               end
            end
            ST_WR_COMMIT: begin
               state_ff <= ST_IDLE;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Write words and their byte keeps gather into one four-word core line.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wbuf_ff  <= '0;
         wkeep_ff <= '0;
      end else if (clk_en && (state_ff == ST_WR_CAPT) && wr_edge) begin
         wbuf_ff[beat_ff*WORD_W +: WORD_W] <= {check_bits_in, dq_in}; // see R13, R15
         wkeep_ff[beat_ff*LANES +: LANES]  <= ~write_byte_mask; // see R18
      end
   end

   // Read pin words leave one per cycle, the strobe flipping with every word.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         word_out_ff <= '0; // see R6
         drive_ff    <= 1'b0;
         strobe_ff   <= 1'b0;
      end else if (clk_en) begin
         drive_ff <= (state_ff == ST_RD_BURST); // see R9
         if (state_ff == ST_RD_BURST) begin
            word_out_ff <= core_rd[beat_ff*WORD_W +: WORD_W]; // see R11, R14
            strobe_ff   <= !beat_ff[0]; // see R9, R14
         end else begin
            word_out_ff <= '0;
            strobe_ff   <= 1'b0;
         end
      end
   end

   // Pin outputs; enables are active low, so reset leaves every pin released.
   assign dq_out             = word_out_ff[DQ_W-1:0]; // see R15
   assign check_bits_out     = word_out_ff[WORD_W-1:DQ_W];
   assign dq_drive_n         = {DQ_W{!drive_ff}};
   assign check_bits_drive_n = {CB_W{!drive_ff}};
   assign dqs_out            = {LANES{strobe_ff}};
   assign dqs_drive_n        = {LANES{!drive_ff}};
   assign dqs_c_out          = {LANES{diff_dqs_ff && drive_ff && !strobe_ff}}; // see R8
   assign dqs_c_drive_n      = {LANES{!(drive_ff && diff_dqs_ff)}}; // see R8

   // The core line moves in one cycle in each direction.
   dmi_core_mem u_core (
      .ref_clk (ref_clk),
      .clk_en  (clk_en),
      .wr_en   (state_ff == ST_WR_COMMIT), // see R11
      .wr_addr (slot_ff),
      .wr_data (wbuf_ff),
      .wr_keep (wkeep_ff), // see R18
      .rd_en   (rd_take),
      .rd_addr (cmd_slot),
      .rd_data (core_rd)
   );

   // Straps are slow pins from outside, filtered before use.
   dmi_pin_sync #(
      .W (2)
   ) u_presence_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .pin     (presence_addr_select),
      .level   (presence_sel)
   );

   // The straps pick one of four presence-detect bus addresses.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         presence_dev_addr <= 7'h00;
      end else if (clk_en) begin
         presence_dev_addr <= {PRESENCE_BASE, presence_sel}; // see R17
      end
   end

   // Checks hold only while the block runs; a frozen block proves nothing.
   default clocking dmi_cb @(posedge ref_clk);
   endclocking
   default disable iff (rst || !clk_en);

   term_follow_a: assert property ((clk_en && ck_pos) |=> (data_term_on == $past(odt_allow_ff && termination_enable))) // see R1
      else $error("Termination does not follow the sampled enable.");
   term_ignored_a: assert property ((ck_pos && !odt_allow_ff) |=> !data_term_on) // see R3
      else $error("Termination came on while disabled by mode.");
   cs_gate_a: assert property ((chip_select_n && state_ff == ST_IDLE) |=> (state_ff == ST_IDLE)) // see R5
      else $error("Command taken with chip select high.");
   cke_gate_a: assert property ((!cke_ff && state_ff == ST_IDLE) |=> (state_ff == ST_IDLE)) // see R19
      else $error("Command taken with clock enable low.");
   read_latency_a: assert property (rd_take |-> ##RD_FIRST (dq_drive_n[0] == 1'b0)) // see R12
      else $error("First read word not on time.");
   burst_length_a: assert property ($fell(dqs_drive_n[0]) |-> !dqs_drive_n[0] [*4] ##1 dqs_drive_n[0]) // see R11
      else $error("Read burst is not four words long.");
   strobe_align_a: assert property ((!dqs_drive_n[0] && $past(!dqs_drive_n[0])) |-> (dqs_out[0] != $past(dqs_out[0]))) // see R9
      else $error("Read strobe did not flip with the data word.");
   diff_strobe_a: assert property (!diff_dqs_ff |-> (dqs_c_drive_n == '1)) // see R8
      else $error("Complementary strobe driven in single mode.");
   write_count_a: assert property ((state_ff == ST_WR_CAPT && wr_edge && beat_ff == 2'h3) |=> (state_ff == ST_WR_COMMIT)) // see R13
      else $error("Fourth write word did not commit.");
   mask_keep_a: assert property ((state_ff == ST_WR_CAPT && wr_edge && write_byte_mask[0]) |=> !wkeep_ff[$past(beat_ff)*LANES]) // see R18
      else $error("Masked byte marked for writing.");

   read_burst_c: cover property (rd_take ##RD_FIRST !dq_drive_n[0]);
   write_commit_c: cover property (state_ff == ST_WR_COMMIT);
   diff_read_c: cover property (!dqs_c_drive_n[0]);
   term_on_c: cover property (data_term_on);
endmodule
`default_nettype wire

/* File: verif/dmi_ctrl_model.sv */
// Memory controller model: memory clock, command pins, termination and write strobes.
`timescale 1ns/100ps
`default_nettype none
module dmi_ctrl_model (
   // Clock and reset.
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   // Memory clock, command and termination.
   output logic                             ck_t,
   output logic                             ck_c,
   output logic                             cke,
   output logic                             cs_n,
   output logic      [2:0]                  cmd,
   output logic      [dmi_pkg::ADDR_W-1:0]  addr,
   output logic      [dmi_pkg::BA_W-1:0]    ba,
   output logic                             odt,
   // Write side.
   output logic      [dmi_pkg::WORD_W-1:0]  wd,
   output logic      [dmi_pkg::LANES-1:0]   dm,
   output logic                             dqs,
   output logic                             dqs_c
);
   import dmi_pkg::*;
   logic cke_en;
   // Command lines start idle, termination low and data released.
   initial begin
      cs_n = 1'b1;
      cmd = 3'h7;
      addr = '0;
      ba = '0;
      odt = 1'b0;
      wd = '0;
      dm = '0;
      dqs = 1'b0;
      dqs_c = 1'b1;
      cke_en = 1'b1;
      ck_t = 1'b0;
   end
   // Memory clock toggles each cycle; a cycle with ck_t high after low is a positive edge.
   always @(negedge ref_clk) ck_t <= ~ck_t;
   assign ck_c = ~ck_t;
   // Clock enable is held low through reset so the module powers up quiet.
   always @(negedge ref_clk or posedge rst)
      if (rst) cke <= 1'b0; else cke <= cke_en;

   // Sets termination and clock enable, then lets a few memory clock edges sample them.
   task automatic pins(input logic o, input logic c);
      @(negedge ref_clk);
      odt <= o;
      cke_en <= c;
      repeat (4) @(negedge ref_clk);
   endtask

   // Places one command for a whole memory clock period around a positive edge.
   // Afterwards the address lines show the inverse, so a late sample of them would show.
   task automatic issue(input logic sel_n, input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
      @(negedge ref_clk);
      while (ck_t !== 1'b0) @(negedge ref_clk);
      cs_n <= sel_n;
      cmd <= c;
      ba <= b;
      addr <= a;
      repeat (2) @(negedge ref_clk);
      cs_n <= 1'b1;
      cmd <= 3'h7;
      ba <= ~b;
      addr <= ~a;
   endtask

   // Four strobe edges each carry one word; afterwards the data shows the inverse of the last word, the mask clears and the strobe flips again.
   task automatic burst(input logic [3:0][71:0] w, input logic [3:0][8:0] m, input logic diff);
      for (int k = 0; k < 4; k++) begin
         wd <= w[k];
         dm <= m[k];
         dqs <= ~dqs;
         dqs_c <= diff ? dqs : ~dqs;
         @(negedge ref_clk);
      end
      wd <= ~w[3];
      dm <= '0;
      dqs <= ~dqs;
      dqs_c <= ~dqs_c;
   endtask
endmodule
`default_nettype wire

/* File: verif/ddr2_module_command_data_interface_tb.sv */
// Self-checking bench for the module command, termination and data interface.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module ddr2_module_command_data_interface_tb;
   import dmi_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] strap = 2'h0;
   logic clk_en = 1'b1;
   int num_errors = 0;
   int checks_done = 0;
   wire logic ck_t, ck_c, cke, cs_n, odt, dqs, dqs_c, data_term_on;
   wire logic [2:0] cmd, ba;
   wire logic [15:0] addr;
   wire logic [71:0] wd;
   wire logic [8:0] dm, dqs_out, dqs_drive_n, dqs_c_out, dqs_c_drive_n;
   wire logic [6:0] presence_dev_addr;
   wire logic [63:0] dq_out, dq_drive_n;
   wire logic [7:0] cb_out, cb_drive_n;
   wire logic [71:0] rd_word = {cb_out, dq_out};

   // Clock at 200 MHz.
   always #2.5 ref_clk = ~ref_clk;

   dmi_ctrl_model ctl (.ref_clk(ref_clk), .rst(rst), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n),
      .cmd(cmd), .addr(addr), .ba(ba), .odt(odt), .wd(wd), .dm(dm), .dqs(dqs), .dqs_c(dqs_c));

   // Each shared wire carries the module's value where it drives, otherwise the controller's.
   dmi_module_if #(.DENSITY(DEN_1G)) uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .ck_t(ck_t),
      .ck_c(ck_c), .clock_enable_in(cke), .chip_select_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]),
      .we_n(cmd[0]), .addr(addr), .bank_addr(ba), .termination_enable(odt), .data_term_on(data_term_on),
      .presence_addr_select(strap), .presence_dev_addr(presence_dev_addr),
      .dq_in((dq_out & ~dq_drive_n) | (wd[63:0] & dq_drive_n)), .dq_out(dq_out), .dq_drive_n(dq_drive_n),
      .check_bits_in((cb_out & ~cb_drive_n) | (wd[71:64] & cb_drive_n)), .check_bits_out(cb_out),
      .check_bits_drive_n(cb_drive_n), .write_byte_mask(dm),
      .dqs_in((dqs_out & ~dqs_drive_n) | ({9{dqs}} & dqs_drive_n)), .dqs_out(dqs_out),
      .dqs_drive_n(dqs_drive_n), .dqs_c_in((dqs_c_out & ~dqs_c_drive_n) | ({9{dqs_c}} & dqs_c_drive_n)),
      .dqs_c_out(dqs_c_out), .dqs_c_drive_n(dqs_c_drive_n));

   // Distinct bytes per word so a wrong word or a leaked mask shows.
   function automatic logic [3:0][71:0] gen(input logic [7:0] s);
      for (int k = 0; k < 4; k++)
         gen[k] = {9{s + 8'(k * 16)}};
   endfunction

   task automatic wr(input logic [2:0] b, input logic [3:0][71:0] w, input logic [3:0][8:0] mk, input logic df);
      ctl.issue(1'b0, CMD_WRITE, b, 16'h0000);
      ctl.burst(w, mk, df);
      repeat (2) @(negedge ref_clk);
   endtask

   // Words appear one per cycle from the fourth edge after the command, strobe aligned.
   task automatic rd_check(input logic [2:0] b, input logic [3:0][71:0] w, input logic df);
      ctl.issue(1'b0, CMD_READ, b, 16'h0000);
      repeat (2) @(negedge ref_clk);
      for (int k = 0; k < 4; k++) begin
         `CHK(rd_word, w[k])
         `CHK(dqs_out, {LANES{~k[0]}})
         `CHK(dqs_c_out, {LANES{df & k[0]}})
         `CHK({cb_drive_n, dqs_drive_n, dqs_c_drive_n}, {17'h0_0000, {LANES{~df}}})
         `CHK(dq_drive_n, 64'h0)
         @(negedge ref_clk);
      end
      `CHK(dq_drive_n, {DQ_W{1'b1}})
      `CHK({cb_drive_n, dqs_drive_n, dqs_c_drive_n}, {26{1'b1}})
   endtask

   // A strap change while the block is frozen must not move the address; once running it settles.
   task automatic t_presence();
      for (int s = 0; s < 4; s++) begin
         clk_en = 1'b0;
         strap = 2'(s);
         repeat (6) @(negedge ref_clk);
         `CHK(presence_dev_addr, (s == 0) ? 7'h00 : {PRESENCE_BASE, 2'(s - 1)})
         clk_en = 1'b1;
         repeat (6) @(negedge ref_clk);
         `CHK(presence_dev_addr, {PRESENCE_BASE, 2'(s)})
      end
   endtask

   task automatic t_term();
      ctl.pins(1'b1, 1'b1);
      `CHK(data_term_on, 1'b0)
      ctl.issue(1'b0, CMD_LOAD_MODE, 3'h0, 16'h0004);
      repeat (3) @(negedge ref_clk);
      `CHK(data_term_on, 1'b0)
      ctl.issue(1'b0, CMD_LOAD_MODE, BA_EXT_MODE, 16'h0004);
      repeat (3) @(negedge ref_clk);
      `CHK(data_term_on, 1'b1)
      ctl.pins(1'b0, 1'b1);
      `CHK(data_term_on, 1'b0)
      ctl.pins(1'b1, 1'b1);
      `CHK(data_term_on, 1'b1)
      ctl.issue(1'b0, CMD_LOAD_MODE, BA_EXT_MODE, 16'h0000);
      repeat (3) @(negedge ref_clk);
      `CHK(data_term_on, 1'b0)
      ctl.pins(1'b0, 1'b1);
   endtask

   // A read with clock enable low, then one with chip select high, must both leave the bus alone.
   task automatic t_ignore();
      for (int i = 0; i < 2; i++) begin
         ctl.pins(1'b0, i[0]);
         ctl.issue(i[0], CMD_READ, 3'h4, 16'h0000);
         repeat (6) begin
            @(negedge ref_clk);
            `CHK(dq_drive_n, {DQ_W{1'b1}})
         end
      end
      ctl.pins(1'b0, 1'b1);
   endtask

   task automatic t_data();
      logic [3:0][71:0] a;
      logic [3:0][71:0] b;
      logic [3:0][71:0] e;
      a = gen(8'h10);
      b = gen(8'h80);
      e = gen(8'h30);
      wr(3'h0, a, '0, 1'b0);
      wr(3'h4, b, '0, 1'b0);
      wr(3'h0, e, {9'h000, 9'h100, 9'h001, 9'h000}, 1'b0);
      e[1][7:0] = a[1][7:0];
      e[2][71:64] = a[2][71:64];
      rd_check(3'h0, e, 1'b0);
      rd_check(3'h4, b, 1'b0);
      ctl.issue(1'b0, CMD_LOAD_MODE, BA_EXT_MODE, 16'h0400);
      a = gen(8'h55);
      wr(3'h2, a, '0, 1'b1);
      rd_check(3'h2, a, 1'b1);
   endtask

   // Reset taken between clock edges must drop the read at once.
   task automatic t_async();
      ctl.issue(1'b0, CMD_READ, 3'h4, 16'h0000);
      repeat (2) @(negedge ref_clk);
      `CHK(dq_drive_n, 64'h0)
      rst <= 1'b1;
      #1;
      `CHK(dq_drive_n, {DQ_W{1'b1}})
      `CHK(dqs_out, 9'h000)
      `CHK(dq_out, 64'h0)
      repeat (20) @(negedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic give_verdict();
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence; reset is held for twenty cycles first.
   initial begin
      repeat (20) @(negedge ref_clk);
      `CHK(dq_drive_n, {DQ_W{1'b1}})
      `CHK(data_term_on, 1'b0)
      rst <= 1'b0;
      t_presence();
      t_term();
      t_ignore();
      t_data();
      t_async();
      give_verdict();
   end

   // The run needs a few hundred cycles; a hang is cut off far beyond that, at four thousand cycles.
   initial begin
      #20000;
      num_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
